// ---- rtl/tsic_defs.vh ----
`ifndef TSIC_DEFS_VH
`define TSIC_DEFS_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define TSIC_ADDR_TRAP      12'h000
`define TSIC_ADDR_GCTL      12'h004
`define TSIC_ADDR_IRQ_STAT  12'h008
`define TSIC_ADDR_IRQ_MASK  12'h00C

// ---------------------------------------------------------------
// Trap status field positions
// ---------------------------------------------------------------
`define TSIC_TRAP_OSC       1
`define TSIC_TRAP_STACK     2
`define TSIC_TRAP_ADDR      3
`define TSIC_TRAP_MATH      4
`define TSIC_TRAP_DMA       5
`define TSIC_TRAP_DIVZ      6
`define TSIC_TRAP_IMPL      16'h007E

// ---------------------------------------------------------------
// Global control field positions and reset
// ---------------------------------------------------------------
`define TSIC_GCTL_GIE       15
`define TSIC_GCTL_TIMED_IRQ_DISABLE_ACTIVE      14
`define TSIC_GCTL_SOFTWARE_TRAP_CONTROL    13
`define TSIC_GCTL_WMASK     16'hA007
`define TSIC_GCTL_RESET     16'h8000

// ---------------------------------------------------------------
// Interrupt status layout: bits 2..0 external edges, 3 any trap
// ---------------------------------------------------------------
`define TSIC_IRQ_TRAP       3
`define TSIC_IRQ_WIDTH      4

`endif

// ---- rtl/tsic_edge_detect.v ----
`timescale 1ns/10ps
`default_nettype none

module tsic_edge_detect #(
  parameter N = 3
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Pins and polarity
  input  wire [N-1:0] pin,
  input  wire [N-1:0] falling,
  // Events
  output reg  [N-1:0] edge_seen
);

  reg [N-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_ch
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev[i]      <= 1'b0;
          edge_seen[i] <= 1'b0;
        end else begin
          prev[i]      <= pin[i];
          // One selects falling edge, zero rising
          edge_seen[i] <= falling[i] ? (prev[i] & ~pin[i]) : (~prev[i] & pin[i]);
        end
      end
    end
  endgenerate

endmodule // tsic_edge_detect

`default_nettype wire

// ---- rtl/tsic_trap_flags.v ----
`timescale 1ns/10ps
`default_nettype none
`include "tsic_defs.vh"

module tsic_trap_flags (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Trap events
  input  wire        trap_osc,
  input  wire        trap_stack,
  input  wire        trap_addr,
  input  wire        trap_math,
  input  wire        trap_divz,
  input  wire        trap_dma,
  // Software write
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  // Flags
  output reg  [15:0] flags
);

  reg [15:0] set_vec;

  always @* begin
    set_vec = 16'h0000;
    set_vec[`TSIC_TRAP_OSC]   = trap_osc;
    set_vec[`TSIC_TRAP_STACK] = trap_stack;
    set_vec[`TSIC_TRAP_ADDR]  = trap_addr;
    // A divide-by-zero is a math trap as well
    set_vec[`TSIC_TRAP_MATH]  = trap_math | trap_divz;
    set_vec[`TSIC_TRAP_DIVZ]  = trap_divz;
    set_vec[`TSIC_TRAP_DMA]   = trap_dma;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 16'h0000;
    end else if (wr_en) begin
      // Hardware set wins over a software clear in the same cycle
      flags <= ((wr_data | set_vec) & `TSIC_TRAP_IMPL);
    end else begin
      flags <= flags | set_vec;
    end
  end

endmodule // tsic_trap_flags

`default_nettype wire

// ---- rtl/tsic_top.v ----
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tsic_defs.vh"

module tsic_top (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Trap events from the core, one-cycle pulses
  input  wire        trap_osc,
  input  wire        trap_stack,
  input  wire        trap_addr,
  input  wire        trap_math,
  input  wire        trap_divz,
  input  wire        trap_dma,
  // Core status and requests
  input  wire        timed_irq_disable_active,
  input  wire [2:0]  ext_irq_pin,
  input  wire        periph_irq_req,
  // Outputs to the core
  output reg         core_irq_take,
  output reg         software_trap_enable,
  output reg  [2:0]  ext_irq_event,
  output reg         irq
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire access  = psel & penable;
  wire wr_acc  = access & pwrite;
  wire rd_acc  = access & ~pwrite;
  wire hit_trp = (paddr == `TSIC_ADDR_TRAP);
  wire hit_gct = (paddr == `TSIC_ADDR_GCTL);
  wire hit_ist = (paddr == `TSIC_ADDR_IRQ_STAT);
  wire hit_msk = (paddr == `TSIC_ADDR_IRQ_MASK);
  wire hit_any = hit_trp | hit_gct | hit_ist | hit_msk;

  // ---------------------------------------------------------------
  // Global interrupt control
  // ---------------------------------------------------------------
  reg  [15:0] global_interrupt_control;
  reg         timed_irq_disable_active_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_interrupt_control <= `TSIC_GCTL_RESET;
    end else if (wr_acc & hit_gct) begin
      // Status bit fourteen and the gaps are not writable
      global_interrupt_control <= pwdata[15:0] & `TSIC_GCTL_WMASK;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timed_irq_disable_active_q <= 1'b0;
    end else begin
      timed_irq_disable_active_q <= timed_irq_disable_active;
    end
  end

  wire global_irq_enable  = global_interrupt_control[`TSIC_GCTL_GIE];
  wire [2:0] polarity     = global_interrupt_control[2:0];
  wire [15:0] gctl_read   = global_interrupt_control |
                            ({15'h0000, timed_irq_disable_active_q} << `TSIC_GCTL_TIMED_IRQ_DISABLE_ACTIVE);

  // ---------------------------------------------------------------
  // Trap flags and edge detectors
  // ---------------------------------------------------------------
  wire [15:0] trap_status_control;
  wire [2:0]  edge_evt;

  tsic_trap_flags u_flags (
    .pclk       (pclk),
    .presetn    (presetn),
    .trap_osc   (trap_osc),
    .trap_stack (trap_stack),
    .trap_addr  (trap_addr),
    .trap_math  (trap_math),
    .trap_divz  (trap_divz),
    .trap_dma   (trap_dma),
    .wr_en      (wr_acc & hit_trp),
    .wr_data    (pwdata[15:0]),
    .flags      (trap_status_control)
  );

  tsic_edge_detect #(
    .N (3)
  ) u_edge (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin       (ext_irq_pin),
    .falling   (polarity),
    .edge_seen (edge_evt)
  );

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  reg  [`TSIC_IRQ_WIDTH-1:0] irq_stat;
  reg  [`TSIC_IRQ_WIDTH-1:0] irq_mask;
  wire any_trap = trap_osc | trap_stack | trap_addr | trap_math | trap_divz | trap_dma;
  wire [`TSIC_IRQ_WIDTH-1:0] irq_set = {any_trap, edge_evt};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {`TSIC_IRQ_WIDTH{1'b0}};
    end else if (rd_acc & hit_ist) begin
      // Read clears, but an event in the same cycle survives
      irq_stat <= irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= {`TSIC_IRQ_WIDTH{1'b0}};
    end else if (wr_acc & hit_msk) begin
      irq_mask <= pwdata[`TSIC_IRQ_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_take        <= 1'b0;
      software_trap_enable <= 1'b0;
      ext_irq_event        <= 3'h0;
      irq                  <= 1'b0;
    end else begin
      // Traps bypass this gate; only maskable requests are held back
      core_irq_take        <= periph_irq_req & global_irq_enable;
      software_trap_enable <= global_interrupt_control[`TSIC_GCTL_SOFTWARE_TRAP_CONTROL];
      ext_irq_event        <= edge_evt;
      irq                  <= |(irq_stat & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // APB answer: zero wait states, error on unmapped address
  // ---------------------------------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `TSIC_ADDR_TRAP:     rd_mux = {16'h0000, trap_status_control};
      `TSIC_ADDR_GCTL:     rd_mux = {16'h0000, gctl_read};
      `TSIC_ADDR_IRQ_STAT: rd_mux = {28'h0000000, irq_stat};
      `TSIC_ADDR_IRQ_MASK: rd_mux = {28'h0000000, irq_mask};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Ready is registered at the end of the setup cycle so the access phase ends at once
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // tsic_top

`default_nettype wire

// ---- dv/tsic_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsic_core_model (
  input  wire logic       pclk,
  input  wire logic [5:0] fire,
  output var  logic [5:0] trap
);
  // The core raises each trap for one cycle, a clock after it is asked for
  initial trap = '0;
  always @(posedge pclk) trap <= fire;
endmodule // tsic_core_model
`default_nettype wire

// ---- dv/tsic_top_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module tsic_top_assertions (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side
  input wire logic        periph_irq_req,
  input wire logic        core_irq_take,
  input wire logic        software_trap_enable,
  input wire logic [2:0]  ext_irq_pin,
  input wire logic [2:0]  ext_irq_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd = pready && !pwrite;
  wire logic gw = psel && penable && pwrite && paddr == 12'h004;
  ready_timing_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  map_err_a: assert property (pready && paddr[11:4] != 0 |-> pslverr) else $error("no pslverr");
  trap_zero_a: assert property (rd && paddr == 12'h000 |-> prdata[31:7] == 0 && !prdata[0])
    else $error("trap spare bits set");
  gctl_zero_a: assert property (rd && paddr == 12'h004 |-> prdata[31:16] == 0 && prdata[12:3] == 0)
    else $error("gctl spare bits set");
  edge_cause_a: assert property (ext_irq_event[0] |->
    $past(ext_irq_pin[0]) != $past(ext_irq_pin[0], 2) || $past(ext_irq_pin[0], 2) != $past(ext_irq_pin[0], 3))
    else $error("event without edge");
  software_trap_control_cause_a: assert property ($changed(software_trap_enable) |-> $past(gw) || $past(gw, 2))
    else $error("sw trap moved alone");
  take_cause_a: assert property (core_irq_take |-> $past(periph_irq_req)) else $error("take alone");
endmodule // tsic_top_assertions
bind tsic_top tsic_top_assertions chk_u (.*);
`default_nettype wire

// ---- dv/trap_status_and_int_control_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module trap_status_and_int_control_bench;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, err;
  logic        timed_irq_disable_active = '0, periph_irq_req = '0;
  logic        pready, pslverr, core_irq_take, software_trap_enable, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv, v;
  logic [5:0]  fire = '0, trap;
  logic [2:0]  ext_irq_pin = '0, ext_irq_event;
  int          num_errors = 0, cmp_count = 0;
  tsic_core_model core_u (.pclk(pclk), .fire(fire), .trap(trap));
  tsic_top dut_u (.*, .trap_osc(trap[0]), .trap_stack(trap[1]), .trap_addr(trap[2]),
    .trap_math(trap[3]), .trap_dma(trap[4]), .trap_divz(trap[5]));
  always #5 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rv);
  endtask
  task automatic fire_trap(input int i);
    @(posedge pclk);
    fire <= 6'h01 << i;
    @(posedge pclk);
    fire <= 6'h00;
  endtask
  task automatic pin_step(input int i, input logic l, input logic e);
    int c = 0;
    @(posedge pclk);
    ext_irq_pin[i] <= l;
    repeat (4) begin
      @(posedge pclk);
      c += (ext_irq_event[i] === 1'b1);
    end
    chk("edge event", e, c);
  endtask
  // Divide-by-zero is a math trap too, so it shows in both flags
  function automatic logic [31:0] exp_trap(input int i);
    return (i == 5) ? 32'h50 : 32'h2 << i;
  endfunction
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run is under a thousand cycles
  initial begin
    #50us;
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h82032465));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h0, "trap reset");
    rdc(12'h004, 32'h8000, "gctl reset");
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      fire_trap(i);
      rdc(12'h000, exp_trap(i), "trap flag");
      rdc(12'h000, exp_trap(i), "trap sticky");
      xfer(1'b1, 12'h000, 32'h0);
      rdc(12'h000, 32'h0, "trap clear");
    end
    xfer(1'b1, 12'h000, 32'hFFFFFFFF);
    rdc(12'h000, 32'h7E, "trap write");
    xfer(1'b1, 12'h000, 32'h0);
    $display("trap flags done");
    periph_irq_req <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $urandom;
      timed_irq_disable_active <= v[22];
      xfer(1'b1, 12'h004, v);
      rdc(12'h004, (v & 32'hA007) | {v[22], 14'h0}, "gctl value");
      chk("sw trap", v[13], software_trap_enable);
      chk("irq take", v[15], core_irq_take);
    end
    $display("control done");
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 2; p++) begin
        xfer(1'b1, 12'h004, p ? 32'h1 << i : 32'h0);
        pin_step(i, 1'b1, p == 0);
        pin_step(i, 1'b0, p == 1);
      end
    end
    $display("edges done");
    xfer(1'b0, 12'h008, 32'h0);
    xfer(1'b1, 12'h00C, 32'h8);
    fire_trap(2);
    repeat (3) @(posedge pclk);
    chk("irq set", 32'h1, irq);
    rdc(12'h008, 32'h8, "irq status");
    repeat (3) @(posedge pclk);
    chk("irq clear", 32'h0, irq);
    xfer(1'b1, 12'h00C, 32'h0);
    fire_trap(3);
    repeat (3) @(posedge pclk);
    chk("irq masked", 32'h0, irq);
    $display("interrupt done");
    rdc(12'h010, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, err);
    $display("unmapped done");
    close_out();
  end
endmodule // trap_status_and_int_control_bench
`default_nettype wire
